// [verif/frp_host.sv]
// Host-side serial controller model: mode 0, MSB first
module frp_host (
  output logic      sck,  // Serial clock, low outside frames
  output logic      cs_n, // Chip select, active low
  output logic      si,   // Serial data to the device
  input  wire logic so    // Serial data from the device
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end
  // One frame: command byte, then one byte sent while one is captured
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, dat};
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      si = sh[i];
      #200;
      sck = 1'b1;
      if (i < 8) begin
        rd[i] = so;
      end
      #200;
      sck = 1'b0;
    end
    #200;
    cs_n = 1'b1;
    // Released line shows the inverse so a stale bit is never mistaken for data
    si = ~si;
    #800;
  endtask : xfer
endmodule : frp_host

// [verif/tb_top.sv]
// Self-checking bench for the function and read-parameter registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import frp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, qe = 1'b0, qpi = 1'b0;
  logic sus = 1'b0, res = 1'b0, pact = 1'b0, eact = 1'b0, req = 1'b0;
  logic ld = 1'b0, step = 1'b0, ok, refd, sck, cs_n, si, so, so_oe_n, wrap, ded_d;
  logic [1:0] row = 2'b00;
  logic [3:0] ddef = 4'h8, dcnt;
  logic [6:0] burst;
  logic [20:0] start = 21'h0, addr;
  frp_pin_t pin, pin_d;
  logic [31:0] seed = 32'h10EBD3CD;
  int bad_count = 0;
  int compares = 0;
  always #25 clk = ~clk;
  // Second copy has a dedicated reset pin, so the forced-hold path gets exercised too
  for (genvar g = 0; g < 2; g++) begin : g_var
    if (g == 0) begin : g_sel
      frp_regs frp_regs_inst (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
        .so(so), .so_oe_n(so_oe_n), .write_enable(we), .quad_enable(qe), .qpi_mode(qpi),
        .suspend_req(sus), .resume_req(res), .program_active(pact), .erase_active(eact),
        .ir_prog_req(req), .ir_prog_row(row), .ir_prog_ok(ok), .ir_prog_refused(refd),
        .default_dummy(ddef), .dummy_count(dcnt), .shared_pin_mode(pin),
        .dedicated_rst_en(), .wrap_enable(wrap), .burst_bytes(burst), .rd_addr_load(ld),
        .rd_addr_start(start), .rd_addr_step(step), .rd_addr(addr));
    end else begin : g_ded
      frp_regs #(.HAS_DEDICATED_RESET(1'b1)) frp_regs_inst (.clk(clk), .rst_n(rst_n),
        .sck(sck), .cs_n(cs_n), .si(si), .so(), .so_oe_n(), .write_enable(we),
        .quad_enable(qe), .qpi_mode(qpi), .suspend_req(sus), .resume_req(res),
        .program_active(pact), .erase_active(eact), .ir_prog_req(req), .ir_prog_row(row),
        .ir_prog_ok(), .ir_prog_refused(), .default_dummy(ddef), .dummy_count(),
        .shared_pin_mode(pin_d), .dedicated_rst_en(ded_d), .wrap_enable(), .burst_bytes(),
        .rd_addr_load(ld), .rd_addr_start(start), .rd_addr_step(step), .rd_addr());
    end
  end
  frp_host frp_host_inst (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    frp_host_inst.xfer(c, d, r);
    @(negedge clk);
  endtask : wr
  task automatic fn(input logic [7:0] e);
    logic [7:0] r;
    frp_host_inst.xfer(CMD_RD_FUNC, 8'h00, r);
    chk(r, e, "function reg");
  endtask : fn
  // Readback plus every decoded control, worked out from the byte written
  task automatic rp(input logic [7:0] d, input logic rdis);
    logic [7:0] r;
    frp_pin_t p, q;
    frp_host_inst.xfer(CMD_RD_RP, 8'h00, r);
    q = (qe | qpi) ? FRP_PIN_DATA3 : rdis ? FRP_PIN_RESET : FRP_PIN_HOLD;
    p = (qe | qpi) ? FRP_PIN_DATA3 : (rdis | d[7]) ? FRP_PIN_RESET : FRP_PIN_HOLD;
    chk(r, d, "read params");
    chk(dcnt, (d[6:3] == 4'h0) ? ddef : d[6:3], "dummy");
    chk(pin, p, "pin mode");
    chk({wrap, burst}, {d[2], 7'h08 << d[1:0]}, "wrap burst");
    chk(pin_d, q, "held pin");
    chk(ded_d, !rdis, "dedicated reset");
  endtask : rp
  task automatic prog(input logic [1:0] w, input logic lk);
    @(negedge clk);
    req = 1'b1;
    row = w;
    @(negedge clk);
    req = 1'b0;
    chk({refd, ok}, {lk, ~lk}, "row program");
  endtask : prog
  task automatic pulse(input logic rs);
    @(negedge clk);
    {res, sus} = {rs, ~rs};
    @(negedge clk);
    {res, sus} = 2'b00;
  endtask : pulse
  task automatic walk(input logic [20:0] s, input logic [20:0] e);
    @(negedge clk);
    {ld, start} = {1'b1, s};
    @(negedge clk);
    {ld, step} = 2'b01;
    @(negedge clk);
    step = 1'b0;
    @(negedge clk);
    chk(addr, e, "read address");
  endtask : walk
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    results();
  end
  initial begin
    logic [7:0] d;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(so_oe_n, 1'b1, "idle output enable");
    fn(8'h00);
    rp(RP_RESET, 1'b0);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      d = (i == 0) ? 8'h83 : (i == 1) ? 8'h7C : seed[7:0];
      {we, qe, qpi, ddef} = {seed[8], seed[9], seed[10] & seed[11], seed[15:12]};
      wr(seed[16] ? CMD_SET_RP_V0 : CMD_SET_RP_V1, d);
      rp(d, 1'b0);
    end
    we = 1'b1;
    wr(CMD_SET_RP_NV, ~d);
    rp(d, 1'b0);
    we = 1'b0;
    wr(CMD_WR_FUNC, 8'hFF);
    fn(8'h00);
    we = 1'b1;
    wr(CMD_WR_FUNC, 8'h2E);
    fn(8'h20);
    for (int i = 0; i < 4; i++) prog(i[1:0], i == 1);
    wr(CMD_WR_FUNC, 8'hD1);
    fn(8'hF1);
    wr(CMD_WR_FUNC, 8'h00);
    fn(8'hF1);
    for (int i = 0; i < 4; i++) prog(i[1:0], 1'b1);
    pact = 1'b1;
    pulse(1'b0);
    fn(8'hF5);
    pact = 1'b0;
    pulse(1'b1);
    fn(8'hF1);
    eact = 1'b1;
    pulse(1'b0);
    fn(8'hF9);
    eact = 1'b0;
    pulse(1'b1);
    fn(8'hF1);
    {qe, qpi} = 2'b00;
    wr(CMD_SET_RP_V0, 8'h04);
    rp(8'h04, 1'b1);
    walk(21'h00000F, 21'h000008);
    wr(CMD_SET_RP_V1, 8'h07);
    walk(21'h0012BF, 21'h001280);
    wr(CMD_SET_RP_V0, 8'h03);
    walk(21'h1FFFFF, 21'h000000);
    results();
  end
endmodule : tb_top

// [verilog/frp_link_if.sv]
// Byte-level link between the serial front end and the register core
interface frp_link_if;
  import frp_pkg::*;
  logic      rx_valid;   // Received byte strobe
  frp_byte_t rx_byte;    // Received byte
  logic      frame_act;  // Chip select asserted
  logic      frame_end;  // Chip select released
  logic      tx_load;    // Load byte for shifting out
  frp_byte_t tx_byte;    // Byte to shift out

  modport front (output rx_valid, rx_byte, frame_act, frame_end, input tx_load, tx_byte);
  modport core  (input rx_valid, rx_byte, frame_act, frame_end, output tx_load, tx_byte);
endinterface : frp_link_if

// [verilog/frp_pkg.sv]
// Shared constants and types for the flash function and read-parameter registers
package frp_pkg;

  // ----------------------------------------------------------------
  // Widths and command codes
  // ----------------------------------------------------------------
  localparam int   BYTE_W = 8;
  typedef logic [BYTE_W-1:0] frp_byte_t;

  localparam frp_byte_t CMD_WR_FUNC   = 8'h42;
  localparam frp_byte_t CMD_RD_FUNC   = 8'h48;
  localparam frp_byte_t CMD_SET_RP_NV = 8'h65;
  localparam frp_byte_t CMD_SET_RP_V0 = 8'hC0;
  localparam frp_byte_t CMD_SET_RP_V1 = 8'h63;
  localparam frp_byte_t CMD_RD_RP     = 8'h61;

  // ----------------------------------------------------------------
  // Function register layout
  // ----------------------------------------------------------------
  localparam int FN_RST_DIS = 0;
  localparam int FN_RSVD    = 1;
  localparam int FN_PROGRAM_SUSPENDED_FLAG    = 2;
  localparam int FN_ERASE_SUSPENDED_FLAG    = 3;
  localparam int FN_LOCK_LO = 4;
  localparam int FN_LOCK_HI = 7;
  localparam int LOCK_N     = FN_LOCK_HI - FN_LOCK_LO + 1;

  // ----------------------------------------------------------------
  // Read parameter register layout
  // ----------------------------------------------------------------
  localparam int RP_PIN_SEL  = 7;
  localparam int RP_DUMMY_HI = 6;
  localparam int RP_DUMMY_LO = 3;
  localparam int RP_WRAP_EN  = 2;
  localparam int RP_BURST_HI = 1;
  localparam int RP_BURST_LO = 0;
  localparam int DUMMY_W     = RP_DUMMY_HI - RP_DUMMY_LO + 1;
  localparam int BURST_W     = RP_BURST_HI - RP_BURST_LO + 1;

  localparam frp_byte_t           RP_RESET          = 8'h00;
  localparam logic [LOCK_N-1:0]   LOCK_RESET        = 4'h0;
  localparam logic [DUMMY_W-1:0]  DUMMY_USE_DEFAULT = 4'h0;
  localparam logic [6:0]          MIN_BURST_BYTES   = 7'h08;

  typedef enum logic [1:0] {
    FRP_PIN_HOLD  = 2'b00,
    FRP_PIN_RESET = 2'b01,
    FRP_PIN_DATA3 = 2'b10
  } frp_pin_t;

  // Burst code 0..3 selects 8, 16, 32 or 64 bytes
  function automatic logic [6:0] frp_burst_bytes(input logic [BURST_W-1:0] code);
    frp_burst_bytes = MIN_BURST_BYTES << code;
  endfunction : frp_burst_bytes

endpackage : frp_pkg

// [verilog/frp_regs.sv]
// Function register and read-parameter register pair of a serial flash
// Behaviour
// - Reset-disable bit sets once, moves reset pin
// - Written OTP ones stay one forever
// - Reset-disable default per variant; others zero
// - Program-suspended flag set on suspend, cleared resume
// - Erase-suspended flag set on suspend, cleared resume
// - Row lock bits block programming their row
// - Volatile copy loaded from persistent at power-up
// - Pin select chooses hold or reset
// - Quad enable or QPI makes pin data line
// - Enabled dedicated reset forces hold function
// - Dummy field gives one to fifteen cycles
// - Dummy field zero uses command default
// - Burst code gives 8/16/32/64 bytes
// - Wrap enable bit, reset off
// - Wrap at array end or burst boundary
// - 65h persistent, C0h/63h volatile copy writes
// - Read parameters reset to zero
module frp_regs #(
  parameter bit HAS_DEDICATED_RESET = 1'b0, // Variant has a dedicated reset pin
  parameter bit RST_DIS_DEFAULT     = 1'b0, // Variant default of reset-disable bit
  parameter int ADDR_W              = 21    // Array address width
) (
  input  wire logic                        clk,              // System clock
  input  wire logic                        rst_n,            // Power-up reset, active low
  input  wire logic                        sck,              // Serial clock pin
  input  wire logic                        cs_n,             // Chip select pin
  input  wire logic                        si,               // Serial data in pin
  output logic                             so,               // Serial data out
  output logic                             so_oe_n,          // Low while so is driven
  input  wire logic                        write_enable,     // Write enable latch state
  input  wire logic                        quad_enable,      // Quad enable status bit
  input  wire logic                        qpi_mode,         // Device in QPI mode
  input  wire logic                        suspend_req,      // Suspend command pulse
  input  wire logic                        resume_req,       // Resume command pulse
  input  wire logic                        program_active,   // Program in progress
  input  wire logic                        erase_active,     // Erase in progress
  input  wire logic                        ir_prog_req,      // Info row program request
  input  wire logic [1:0]                  ir_prog_row,      // Info row index
  output logic                             ir_prog_ok,       // Request granted pulse
  output logic                             ir_prog_refused,  // Request refused pulse
  input  wire logic [frp_pkg::DUMMY_W-1:0] default_dummy,    // Command default dummy count
  output logic [frp_pkg::DUMMY_W-1:0]      dummy_count,      // Dummy cycles to use
  output frp_pkg::frp_pin_t                shared_pin_mode,  // Shared pin function
  output logic                             dedicated_rst_en, // Dedicated reset pin live
  output logic                             wrap_enable,      // Burst wrap active
  output logic [6:0]                       burst_bytes,      // Burst length in bytes
  input  wire logic                        rd_addr_load,     // Load read address
  input  wire logic [ADDR_W-1:0]           rd_addr_start,    // Start address
  input  wire logic                        rd_addr_step,     // Advance read address
  output logic [ADDR_W-1:0]                rd_addr           // Current read address
);
  import frp_pkg::*;

  typedef enum logic [1:0] {
    ST_CMD   = 2'b00,
    ST_WDATA = 2'b01,
    ST_READ  = 2'b10,
    ST_SKIP  = 2'b11
  } frp_state_t;

  frp_link_if link ();

  frp_spi_front u_front (
    .clk     (clk),
    .rst_n   (rst_n),
    .sck     (sck),
    .cs_n    (cs_n),
    .si      (si),
    .so      (so),
    .so_oe_n (so_oe_n),
    .link    (link)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  frp_state_t         state;
  frp_byte_t          cmd_q;
  frp_byte_t          wr_data;
  logic               wr_pend;
  logic               rst_dis;
  logic [LOCK_N-1:0]  locks;
  logic               program_suspended_flag;
  logic               erase_suspended_flag;
  frp_byte_t          rp_nv;
  frp_byte_t          rp_vol;
  logic               pwr_loaded;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire       cmd_rx      = link.rx_valid & (state == ST_CMD);
  wire       is_wr_func  = link.rx_byte == CMD_WR_FUNC;
  wire       is_set_nv   = link.rx_byte == CMD_SET_RP_NV;
  wire       is_set_vol  = (link.rx_byte == CMD_SET_RP_V0) | (link.rx_byte == CMD_SET_RP_V1);
  wire       is_rd_func  = link.rx_byte == CMD_RD_FUNC;
  wire       is_rd_rp    = link.rx_byte == CMD_RD_RP;
  wire       commit      = link.frame_end & wr_pend;
  wire       commit_func = commit & (cmd_q == CMD_WR_FUNC);
  wire       commit_nv   = commit & (cmd_q == CMD_SET_RP_NV);
  wire       commit_vol  = commit & ((cmd_q == CMD_SET_RP_V0) | (cmd_q == CMD_SET_RP_V1));
  // Reserved bit wired to zero
  wire frp_byte_t fn_value = {locks, erase_suspended_flag, program_suspended_flag, 1'b0, rst_dis};
  wire       rd_is_func  = (state == ST_CMD) ? is_rd_func : (cmd_q == CMD_RD_FUNC);

  assign link.tx_load = link.rx_valid & ((state == ST_READ) | (cmd_rx & (is_rd_func | is_rd_rp)));
  assign link.tx_byte = rd_is_func ? fn_value : rp_vol;

  // Persistent writes need the write enable latch; volatile ones do not
  wire frp_state_t cmd_next = (is_rd_func | is_rd_rp) ? ST_READ :
                              ((is_wr_func | is_set_nv) & write_enable) | is_set_vol ?
                              ST_WDATA : ST_SKIP;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ST_CMD;
      cmd_q   <= 8'h00;
      wr_data <= 8'h00;
      wr_pend <= 1'b0;
    end else if (link.frame_end || !link.frame_act) begin
      state   <= ST_CMD;
      wr_pend <= 1'b0;
    end else if (link.rx_valid) begin
      unique case (state)
        ST_CMD: begin
          cmd_q <= link.rx_byte;
          state <= cmd_next;
        end
        ST_WDATA: begin
          wr_data <= link.rx_byte;
          wr_pend <= 1'b1;
          state   <= ST_SKIP;
        end
        ST_READ: state <= ST_READ;
        ST_SKIP: state <= ST_SKIP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Function register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_dis <= RST_DIS_DEFAULT;
      locks   <= LOCK_RESET;
    end else if (commit_func) begin
      rst_dis <= rst_dis | wr_data[FN_RST_DIS];
      locks   <= locks | wr_data[FN_LOCK_HI:FN_LOCK_LO];
    end
  end

  // Set wins over clear so a suspend landing with a resume is not lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_suspended_flag <= 1'b0;
      erase_suspended_flag <= 1'b0;
    end else begin
      if (suspend_req && program_active) begin
        program_suspended_flag <= 1'b1;
      end else if (resume_req) begin
        program_suspended_flag <= 1'b0;
      end
      if (suspend_req && erase_active) begin
        erase_suspended_flag <= 1'b1;
      end else if (resume_req) begin
        erase_suspended_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_prog_ok      <= 1'b0;
      ir_prog_refused <= 1'b0;
    end else begin
      ir_prog_ok      <= ir_prog_req & ~locks[ir_prog_row];
      ir_prog_refused <= ir_prog_req & locks[ir_prog_row];
    end
  end

  // ----------------------------------------------------------------
  // Read parameter pair
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_nv      <= RP_RESET;
      rp_vol     <= RP_RESET;
      pwr_loaded <= 1'b0;
    end else begin
      pwr_loaded <= 1'b1;
      if (!pwr_loaded) begin
        rp_vol <= rp_nv;
      end else if (commit_vol) begin
        rp_vol <= wr_data;
      end
      if (commit_nv) begin
        rp_nv <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoded controls; every read-parameter field is taken from the volatile copy
  // ----------------------------------------------------------------
  wire                 pin_is_data = quad_enable | qpi_mode;
  wire                 ded_live    = HAS_DEDICATED_RESET & ~rst_dis;
  wire [DUMMY_W-1:0]   dummy_fld   = rp_vol[RP_DUMMY_HI:RP_DUMMY_LO];
  wire frp_pin_t       next_pin    = pin_is_data ? FRP_PIN_DATA3 :
                                     rst_dis ? FRP_PIN_RESET :
                                     ded_live ? FRP_PIN_HOLD :
                                     rp_vol[RP_PIN_SEL] ? FRP_PIN_RESET :
                                     FRP_PIN_HOLD;
  wire [DUMMY_W-1:0]   next_dummy  = (dummy_fld == DUMMY_USE_DEFAULT) ?
                                     default_dummy : dummy_fld;
  wire [ADDR_W-1:0]    wrap_mask   = ADDR_W'(burst_bytes) - ADDR_W'(1);
  wire [ADDR_W-1:0]    addr_inc    = rd_addr + ADDR_W'(1);
  wire [ADDR_W-1:0]    next_addr   = wrap_enable ?
                                     (rd_addr & ~wrap_mask) | (addr_inc & wrap_mask) :
                                     addr_inc;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shared_pin_mode  <= FRP_PIN_HOLD;
      dedicated_rst_en <= 1'b0;
      dummy_count      <= DUMMY_USE_DEFAULT;
      wrap_enable      <= 1'b0;
      burst_bytes      <= MIN_BURST_BYTES;
    end else begin
      shared_pin_mode  <= next_pin;
      dedicated_rst_en <= ded_live;
      dummy_count      <= next_dummy;
      wrap_enable      <= rp_vol[RP_WRAP_EN];
      burst_bytes      <= frp_burst_bytes(rp_vol[RP_BURST_HI:RP_BURST_LO]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr <= '0;
    end else if (rd_addr_load) begin
      rd_addr <= rd_addr_start;
    end else if (rd_addr_step) begin
      rd_addr <= next_addr;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A slow host may hold the frame open for any time, so the check starts at the release
  sequence s_commit_vol;
    commit_vol && pwr_loaded;
  endsequence

  property p_rst_dis_sticky;
    @(posedge clk) disable iff (!rst_n) rst_dis |=> rst_dis;
  endproperty
  a_rst_dis_sticky: assert property (p_rst_dis_sticky) else $error("bit 0 cleared");

  property p_locks_sticky;
    @(posedge clk) disable iff (!rst_n) 1'b1 |=> (($past(locks) & ~locks) == 4'h0);
  endproperty
  a_locks_sticky: assert property (p_locks_sticky) else $error("lock bit cleared");

  property p_rsvd_zero;
    @(posedge clk) disable iff (!rst_n) link.tx_load && rd_is_func |-> !link.tx_byte[FN_RSVD];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

  property p_program_suspended_flag_set;
    @(posedge clk) disable iff (!rst_n) suspend_req && program_active |=> program_suspended_flag;
  endproperty
  a_program_suspended_flag_set: assert property (p_program_suspended_flag_set) else $error("program suspend flag not set");

  property p_erase_suspended_flag_clear;
    @(posedge clk) disable iff (!rst_n) resume_req && !(suspend_req && erase_active) |=> !erase_suspended_flag;
  endproperty
  a_erase_suspended_flag_clear: assert property (p_erase_suspended_flag_clear) else $error("erase flag not cleared");

  property p_lock_refuse;
    @(posedge clk) disable iff (!rst_n)
      ir_prog_req && locks[ir_prog_row] |=> ir_prog_refused && !ir_prog_ok;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("locked row not refused");

  property p_pin_data3;
    @(posedge clk) disable iff (!rst_n) pin_is_data |=> shared_pin_mode == FRP_PIN_DATA3;
  endproperty
  a_pin_data3: assert property (p_pin_data3) else $error("shared pin not data line");

  property p_pin_hold_ded;
    @(posedge clk) disable iff (!rst_n)
      ded_live && !pin_is_data |=> shared_pin_mode == FRP_PIN_HOLD;
  endproperty
  a_pin_hold_ded: assert property (p_pin_hold_ded) else $error("hold not forced");

  property p_dummy;
    @(posedge clk) disable iff (!rst_n)
      dummy_fld != DUMMY_USE_DEFAULT |=> dummy_count == $past(dummy_fld);
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy count mismatch");

  property p_vol_keeps_nv;
    @(posedge clk) disable iff (!rst_n)
      s_commit_vol |=> ($stable(rp_nv) && rp_vol == $past(wr_data));
  endproperty
  a_vol_keeps_nv: assert property (p_vol_keeps_nv) else $error("copy disturbed");

  property p_wrap_bound;
    @(posedge clk) disable iff (!rst_n)
      rd_addr_step && !rd_addr_load && wrap_enable |=>
        ((rd_addr & ~wrap_mask) == ($past(rd_addr) & ~$past(wrap_mask)));
  endproperty
  a_wrap_bound: assert property (p_wrap_bound) else $error("wrap left burst block");

endmodule : frp_regs

// [verilog/frp_spi_front.sv]
// Oversampled single-line serial front end, mode 0, MSB first
module frp_spi_front (
  input  wire logic clk,     // System clock
  input  wire logic rst_n,   // Async reset, active low
  input  wire logic sck,     // Serial clock pin
  input  wire logic cs_n,    // Chip select pin, active low
  input  wire logic si,      // Serial data in pin
  output logic      so,      // Serial data out
  output logic      so_oe_n, // Output enable, low while driving
  frp_link_if.front link     // Byte link to core
);
  import frp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] si_s;
  logic       sck_d;
  logic       cs_d;
  logic [2:0] bit_cnt;
  frp_byte_t  rx_sh;
  frp_byte_t  tx_sh;
  logic       drive;

  wire sck_rise = sck_s[1] & ~sck_d;
  wire sck_fall = ~sck_s[1] & sck_d;
  wire sel      = ~cs_s[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s <= 2'h0;
      cs_s  <= 2'h3;
      si_s  <= 2'h0;
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sck_s <= {sck_s[0], sck};
      cs_s  <= {cs_s[0], cs_n};
      si_s  <= {si_s[0], si};
      sck_d <= sck_s[1];
      cs_d  <= cs_s[1];
    end
  end

  // ----------------------------------------------------------------
  // Byte assembly and shift-out
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt       <= 3'h0;
      rx_sh         <= 8'h00;
      link.rx_valid <= 1'b0;
      link.rx_byte  <= 8'h00;
    end else begin
      link.rx_valid <= sel & sck_rise & (bit_cnt == 3'h7);
      if (!sel) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        rx_sh   <= {rx_sh[6:0], si_s[1]};
        if (bit_cnt == 3'h7) begin
          link.rx_byte <= {rx_sh[6:0], si_s[1]};
        end
      end
    end
  end

  // Output bit changes on the falling edge so the host samples it on the next rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh <= 8'h00;
      so    <= 1'b0;
      drive <= 1'b0;
    end else if (!sel) begin
      drive <= 1'b0;
    end else if (link.tx_load) begin
      tx_sh <= link.tx_byte;
      drive <= 1'b1;
    end else if (sck_fall && drive) begin
      so    <= tx_sh[7];
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  assign so_oe_n        = ~drive;
  assign link.frame_act = sel;
  assign link.frame_end = cs_s[1] & ~cs_d;

endmodule : frp_spi_front
